// [rtl/lsau_pkg.sv]
package lsau_pkg;
  localparam int WORD_W = 32;
  localparam int REG_W = 4;
  localparam int IMM_W = 13;
  localparam logic [3:0] REG_SP = 4'hD;
  localparam logic [3:0] REG_PC = 4'hF;
  localparam logic [12:0] ADR_IMM_MAX = 13'hFFF;
  localparam logic [12:0] OFS_ADD_MAX = 13'hFFF;
  localparam logic [12:0] OFS_SUB_MAX = 13'h0FF;
  localparam logic [12:0] IDX_IMM_MAX = 13'h0FF;
  localparam logic [12:0] DUAL_IMM_MAX = 13'h3FC;
  localparam logic [31:0] DUAL_STEP = 32'h0000_0004;
  localparam logic [1:0] SHIFT_MAX = 2'h3;

  typedef enum logic [2:0] {
    OP_ADR = 3'h0,
    OP_LOAD = 3'h1,
    OP_STORE = 3'h2,
    OP_DUAL_LOAD = 3'h3,
    OP_DUAL_STORE = 3'h4
  } lsau_op_type;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } lsau_size_type;

  typedef enum logic [1:0] {
    MD_OFFSET = 2'h0,
    MD_PRE = 2'h1,
    MD_POST = 2'h2,
    MD_REGISTER = 2'h3
  } lsau_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } lsau_state_type;
endpackage : lsau_pkg

// [rtl/lsau_top.sv]
`timescale 1ns/1ps
module lsau_top
  import lsau_pkg::*;
#(
  parameter int DATA_W = WORD_W
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire lsau_op_type req_op,
  input wire lsau_size_type req_size,
  input wire logic req_signed,
  input wire lsau_mode_type req_mode,
  input wire logic req_imm_add,
  input wire logic [IMM_W-1:0] req_imm,
  input wire logic [1:0] left_shift_amount,
  input wire logic [REG_W-1:0] transfer_register,
  input wire logic [REG_W-1:0] second_transfer_register,
  input wire logic [REG_W-1:0] base_register,
  input wire logic [REG_W-1:0] offset_register,
  input wire logic req_conditional,
  input wire logic req_group_last,
  input wire logic [DATA_W-1:0] pc_value,
  input wire logic [DATA_W-1:0] base_value,
  input wire logic [DATA_W-1:0] offset_value,
  input wire logic [DATA_W-1:0] store_data,
  input wire logic [DATA_W-1:0] store_data2,
  input wire logic mem_rvalid,
  input wire logic [DATA_W-1:0] mem_rdata,
  output logic req_ready,
  output logic fault,
  output logic mem_valid,
  output logic mem_write,
  output logic [DATA_W-1:0] mem_addr,
  output logic [3:0] mem_be,
  output logic [DATA_W-1:0] mem_wdata,
  output logic wb_valid,
  output logic [REG_W-1:0] wb_reg,
  output logic [DATA_W-1:0] wb_data,
  output logic base_wb_valid,
  output logic [REG_W-1:0] base_wb_reg,
  output logic [DATA_W-1:0] base_wb_data,
  output logic branch_valid,
  output logic [DATA_W-1:0] branch_target,
  output logic flags_we
);

  function automatic logic is_sp_pc(input logic [REG_W-1:0] r);
    is_sp_pc = (r == REG_SP) || (r == REG_PC);
  endfunction : is_sp_pc

  function automatic logic [3:0] lane_mask(input lsau_size_type sz,
                                           input logic [1:0] a);
    case (sz)
      SZ_BYTE: lane_mask = 4'h1 << a;
      SZ_HALF: lane_mask = 4'h3 << {a[1], 1'b0};
      default: lane_mask = 4'hF;
    endcase
  endfunction : lane_mask

  lsau_state_type state;
  lsau_op_type cur_op;
  lsau_size_type cur_size;
  lsau_mode_type cur_mode;
  logic cur_sgn;
  logic cur_second;
  logic [REG_W-1:0] cur_rt;
  logic [REG_W-1:0] cur_rt2;
  logic [REG_W-1:0] cur_rn;
  logic [DATA_W-1:0] cur_base;
  logic [DATA_W-1:0] cur_calc;
  logic [DATA_W-1:0] first_addr;
  logic [DATA_W-1:0] cur_data2;

  logic acc;
  logic is_dual;
  logic is_load;
  logic bad;
  logic [DATA_W-1:0] imm_ext;
  logic [DATA_W-1:0] adr_sum;
  logic [DATA_W-1:0] calc_addr;
  logic [DATA_W-1:0] acc_addr;
  logic [DATA_W-1:0] rshift;
  logic [DATA_W-1:0] load_val;
  logic last_resp;

  assign acc = req_valid && req_ready;
  assign is_dual = (req_op == OP_DUAL_LOAD) || (req_op == OP_DUAL_STORE);
  assign is_load = (req_op == OP_LOAD) || (req_op == OP_DUAL_LOAD);
  assign imm_ext = {{(DATA_W-IMM_W){1'b0}}, req_imm};
  assign adr_sum = req_imm_add ? pc_value + imm_ext : pc_value - imm_ext;
  assign calc_addr = (req_mode == MD_REGISTER)
    ? base_value + (offset_value << left_shift_amount)
    : (req_imm_add ? base_value + imm_ext : base_value - imm_ext);
  // post-indexed accesses the untouched base
  assign acc_addr = (req_mode == MD_POST) ? base_value : calc_addr;

  always_comb
  begin
    bad = 1'b0;
    if (req_op == OP_ADR)
    begin
      bad = is_sp_pc(transfer_register) || (req_imm > ADR_IMM_MAX);
    end
    else
    begin
      if (is_dual)
      begin
        bad = (req_imm > DUAL_IMM_MAX) || (req_imm[1:0] != 2'h0)
          || (req_mode == MD_REGISTER) || is_sp_pc(second_transfer_register)
          || (transfer_register == REG_PC);
        if ((req_op == OP_DUAL_LOAD) && (transfer_register == second_transfer_register))
        begin
          bad = 1'b1;
        end
      end
      else if (req_mode == MD_OFFSET)
      begin
        bad = req_imm > (req_imm_add ? OFS_ADD_MAX : OFS_SUB_MAX);
      end
      else if (req_mode != MD_REGISTER)
      begin
        bad = req_imm > IDX_IMM_MAX;
      end
      if (is_dual && (req_size != SZ_WORD))
      begin
        bad = 1'b1;
      end
      if (is_load && (req_size != SZ_WORD) && is_sp_pc(transfer_register))
      begin
        bad = 1'b1;
      end
      if (!is_load && (req_signed || (transfer_register == REG_PC)
          || (base_register == REG_PC)))
      begin
        bad = 1'b1;
      end
      if (!is_load && (transfer_register == REG_SP) && (req_size != SZ_WORD))
      begin
        bad = 1'b1;
      end
      if (((req_mode == MD_PRE) || (req_mode == MD_POST))
          && ((base_register == transfer_register)
          || (is_dual && (base_register == second_transfer_register))))
      begin
        bad = 1'b1;
      end
      if ((req_mode == MD_REGISTER)
          && ((base_register == REG_PC) || is_sp_pc(offset_register)))
      begin
        bad = 1'b1;
      end
      if (req_op == OP_LOAD && transfer_register == REG_PC && req_conditional
          && !req_group_last)
      begin
        bad = 1'b1;
      end
    end
  end

  assign rshift = mem_rdata >> {mem_addr[1:0], 3'b000};
  always_comb
  begin
    case (cur_size)
      SZ_BYTE: load_val = cur_sgn ? {{24{rshift[7]}}, rshift[7:0]}
                                  : {24'h0, rshift[7:0]};
      SZ_HALF: load_val = cur_sgn ? {{16{rshift[15]}}, rshift[15:0]}
                                  : {16'h0, rshift[15:0]};
      default: load_val = mem_rdata;
    endcase
  end

  assign last_resp = (state == ST_WAIT) && mem_rvalid
    && !((cur_op == OP_DUAL_LOAD || cur_op == OP_DUAL_STORE) && !cur_second);

  // sequencing and request capture
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ST_IDLE;
      req_ready <= 1'b1;
      cur_op <= OP_ADR;
      cur_size <= SZ_WORD;
      cur_mode <= MD_OFFSET;
      cur_sgn <= 1'b0;
      cur_second <= 1'b0;
      cur_rt <= '0;
      cur_rt2 <= '0;
      cur_rn <= '0;
      cur_base <= '0;
      cur_calc <= '0;
      first_addr <= '0;
      cur_data2 <= '0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (acc && !bad && req_op != OP_ADR)
          begin
            state <= ST_WAIT;
            req_ready <= 1'b0;
            cur_op <= req_op;
            cur_size <= req_size;
            cur_mode <= req_mode;
            cur_sgn <= req_signed;
            cur_second <= 1'b0;
            cur_rt <= transfer_register;
            cur_rt2 <= second_transfer_register;
            cur_rn <= base_register;
            cur_base <= base_value;
            cur_calc <= calc_addr;
            first_addr <= acc_addr;
            cur_data2 <= store_data2;
          end
        end
        ST_WAIT:
        begin
          if (last_resp)
          begin
            state <= ST_IDLE;
            req_ready <= 1'b1;
          end
          else if (mem_rvalid)
          begin
            cur_second <= 1'b1;
          end
        end
        default:
        begin
          state <= ST_IDLE;
          req_ready <= 1'b1;
        end
      endcase
    end
  end

  // memory side; one access in flight, the second word waits for the first answer
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_valid <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= '0;
      mem_be <= 4'h0;
      mem_wdata <= '0;
    end
    else
    begin
      mem_valid <= 1'b0;
      if (state == ST_IDLE && acc && !bad && req_op != OP_ADR)
      begin
        mem_valid <= 1'b1;
        mem_write <= !is_load;
        mem_addr <= acc_addr;
        mem_be <= lane_mask(req_size, acc_addr[1:0]);
        mem_wdata <= store_data << {acc_addr[1:0], 3'b000};
      end
      else if (state == ST_WAIT && mem_rvalid && !last_resp)
      begin
        mem_valid <= 1'b1;
        mem_addr <= first_addr + DUAL_STEP;
        mem_be <= 4'hF;
        mem_wdata <= cur_data2;
      end
    end
  end

  // register file, base and branch results
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wb_valid <= 1'b0;
      wb_reg <= '0;
      wb_data <= '0;
      base_wb_valid <= 1'b0;
      base_wb_reg <= '0;
      base_wb_data <= '0;
      branch_valid <= 1'b0;
      branch_target <= '0;
      fault <= 1'b0;
    end
    else
    begin
      wb_valid <= 1'b0;
      base_wb_valid <= 1'b0;
      branch_valid <= 1'b0;
      fault <= 1'b0;
      if (state == ST_IDLE && acc)
      begin
        fault <= bad;
        if (req_op == OP_ADR && !bad)
        begin
          wb_valid <= 1'b1;
          wb_reg <= transfer_register;
          wb_data <= adr_sum;
        end
      end
      if (state == ST_WAIT && mem_rvalid)
      begin
        if (cur_op == OP_LOAD && cur_rt == REG_PC)
        begin
          // an even target is not a valid state for this core
          fault <= !mem_rdata[0];
          branch_valid <= mem_rdata[0];
          branch_target <= {mem_rdata[DATA_W-1:1], 1'b0};
        end
        else if (cur_op == OP_LOAD || cur_op == OP_DUAL_LOAD)
        begin
          wb_valid <= 1'b1;
          wb_reg <= cur_second ? cur_rt2 : cur_rt;
          wb_data <= load_val;
        end
        if (last_resp && (cur_mode == MD_PRE || cur_mode == MD_POST))
        begin
          base_wb_valid <= 1'b1;
          base_wb_reg <= cur_rn;
          base_wb_data <= cur_calc;
        end
      end
    end
  end

  // flags are never touched by this unit
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flags_we <= 1'b0;
    end
    else
    begin
      flags_we <= 1'b0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_take_mem;
    acc && !bad && req_op != OP_ADR;
  endsequence
  sequence s_pc_load_resp;
    state == ST_WAIT && mem_rvalid && cur_op == OP_LOAD && cur_rt == REG_PC;
  endsequence

  a_adr_result: assert property (acc && req_op == OP_ADR && !bad
    |=> wb_valid && wb_data == $past(adr_sum))
    else $error("address result wrong");
  a_adr_range: assert property (acc && req_op == OP_ADR && req_imm > ADR_IMM_MAX
    |=> fault && !wb_valid)
    else $error("out of range address immediate accepted");
  a_take_issue: assert property (s_take_mem |=> mem_valid && !req_ready
    && mem_addr == $past(acc_addr))
    else $error("access not issued at computed address");
  a_post_addr: assert property (mem_valid && !cur_second && cur_mode == MD_POST
    |-> mem_addr == cur_base)
    else $error("post-indexed access not at base");
  a_pre_wb: assert property (base_wb_valid && cur_mode == MD_PRE
    |-> base_wb_data == first_addr)
    else $error("pre-indexed writeback mismatch");
  a_dual_second: assert property (mem_valid && cur_second
    |-> mem_addr == first_addr + DUAL_STEP)
    else $error("second word address wrong");
  a_zero_ext: assert property (state == ST_WAIT && mem_rvalid && cur_op == OP_LOAD
    && cur_size == SZ_BYTE && !cur_sgn && cur_rt != REG_PC
    |=> wb_valid && wb_data[31:8] == 24'h0)
    else $error("byte load not zero-extended");
  a_sign_ext: assert property (state == ST_WAIT && mem_rvalid && cur_op == OP_LOAD
    && cur_size == SZ_HALF && cur_sgn
    |=> wb_data[31:16] == {16{wb_data[15]}})
    else $error("halfword load not sign-extended");
  a_store_lane: assert property (mem_valid && mem_write && cur_size == SZ_BYTE
    |-> $countones(mem_be) == 1)
    else $error("byte store wrote several lanes");
  a_bad_refused: assert property (acc && bad |=> fault && !mem_valid
    ##1 !mem_valid)
    else $error("illegal request was carried out");
  a_pc_branch: assert property (s_pc_load_resp ##0 mem_rdata[0]
    |=> branch_valid && !branch_target[0] && !wb_valid)
    else $error("pc load did not branch to even address");
  a_reg_no_wb: assert property (cur_mode == MD_REGISTER || cur_mode == MD_OFFSET
    |-> !base_wb_valid)
    else $error("base written in non-indexed mode");
  a_flags_hold: assert property (acc |-> ##[1:3] !flags_we)
    else $error("flags written");

endmodule : lsau_top

// [bench/lsau_mem_model.sv]
`timescale 1ns/1ps
// word memory on the far side; one access outstanding, answer after lat cycles
module lsau_mem_model
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic mem_valid,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] mem_be,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] lat,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [16];
  logic pend;
  logic [3:0] cnt;
  logic [3:0] idx;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend <= 1'b0;
      cnt <= 4'h0;
      idx <= 4'h0;
      mem_rvalid <= 1'b0;
      mem_rdata <= 32'h0;
      for (int i = 0; i < 16; i++)
        mem[i] <= 32'h80F1_7F00 | i;
    end
    else
    begin
      mem_rvalid <= 1'b0;
      // stale data toggles so a late sample cannot pass by luck
      mem_rdata <= ~mem_rdata;
      if (mem_valid)
      begin
        pend <= 1'b1;
        cnt <= lat;
        idx <= mem_addr[5:2];
        for (int b = 0; b < 4; b++)
          if (mem_write && mem_be[b])
            mem[mem_addr[5:2]][8*b+:8] <= mem_wdata[8*b+:8];
      end
      else if (pend && cnt <= 4'h1)
      begin
        pend <= 1'b0;
        mem_rvalid <= 1'b1;
        mem_rdata <= mem[idx];
      end
      else if (pend)
        cnt <= cnt - 4'h1;
    end
  end
endmodule : lsau_mem_model

// [bench/test_lsau_top.sv]
`timescale 1ns/1ps
module test_lsau_top;
  import lsau_pkg::*;
  logic clk = 0, rstn = 0, req_valid = 0, req_signed, req_imm_add, req_conditional;
  logic req_group_last, mem_rvalid, req_ready, fault, mem_valid, mem_write, wb_valid;
  logic base_wb_valid, branch_valid, flags_we;
  lsau_op_type req_op;
  lsau_size_type req_size;
  lsau_mode_type req_mode;
  logic [12:0] req_imm;
  logic [1:0] left_shift_amount;
  logic [3:0] transfer_register, second_transfer_register, base_register, offset_register;
  logic [3:0] mem_be, wb_reg, base_wb_reg, lat;
  logic [31:0] pc_value, base_value, offset_value, store_data, store_data2, mem_rdata;
  logic [31:0] mem_addr, mem_wdata, wb_data, base_wb_data, branch_target, wd, brt;
  logic [35:0] wbq [$];
  logic [36:0] mq [$];
  logic [35:0] bwb;
  int flt, bcnt, brn, err_count, cmp_count;

  lsau_top u_dut (.*);
  lsau_mem_model u_mem (.*);

  always #10 clk = ~clk;

  always @(posedge clk)
  begin
    if (rstn)
    begin
      if (flags_we !== 1'b0)
      begin
        err_count++;
        $display("unexpected flags_we: expected 0, seen %b", flags_we);
      end
      if (wb_valid) wbq.push_back({wb_reg, wb_data});
      if (mem_valid) mq.push_back({mem_write, mem_be, mem_addr});
      if (mem_valid) wd = mem_wdata;
      if (base_wb_valid) bwb = {base_wb_reg, base_wb_data};
      if (base_wb_valid) bcnt++;
      if (fault) flt++;
      if (branch_valid) brt = branch_target;
      if (branch_valid) brn++;
    end
  end

  function logic [31:0] wat(input logic [31:0] a);
    return 32'h80F1_7F00 | {28'h0, a[5:2]};
  endfunction : wat

  task automatic chk(input string nm, input logic [36:0] e, input logic [36:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task final_report;
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  task rq(input lsau_op_type o, input lsau_size_type s, input lsau_mode_type m,
          input logic [12:0] i);
    req_op = o;
    req_size = s;
    req_mode = m;
    req_imm = i;
    req_signed = 0;
    req_imm_add = 1;
    req_conditional = 0;
    req_group_last = 0;
    left_shift_amount = 2'h0;
    transfer_register = 4'h1;
    second_transfer_register = 4'h2;
    base_register = 4'h5;
    offset_register = 4'h6;
  endtask : rq

  // one request, then wait until the unit is idle and its pulses are logged
  task go;
    int n;
    wbq.delete();
    mq.delete();
    bwb = '0;
    {flt, bcnt, brn} = '0;
    req_valid = 1;
    @(posedge clk);
    #1 req_valid = 0;
    n = 0;
    repeat (2) @(posedge clk);
    #1;
    while (req_ready !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 60)
    begin
      err_count++;
      final_report();
    end
    repeat (2) @(posedge clk);
    #1;
  endtask : go

  task bad;
    go();
    chk("fault", 1, flt);
    chk("issued", 0, mq.size() + wbq.size());
  endtask : bad

  task t_adr;
    pc_value = 32'h0000_2000;
    rq(OP_ADR, SZ_WORD, MD_OFFSET, 13'h0FFF);
    go();
    chk("adr add", {4'h1, 32'h0000_2FFF}, wbq[0]);
    req_imm_add = 0;
    go();
    chk("adr sub", {4'h1, 32'h0000_1001}, wbq[0]);
    req_imm = 13'h1000;
    bad();
    req_imm = 13'h0004;
    transfer_register = REG_SP;
    bad();
    transfer_register = REG_PC;
    bad();
  endtask : t_adr

  task t_ext;
    logic [31:0] e [4] = '{32'hFFFF_FFF1, 32'h0000_00F1, 32'hFFFF_80F1, 32'h0000_80F1};
    base_value = 32'h20;
    for (int k = 0; k < 4; k++)
    begin
      rq(OP_LOAD, lsau_size_type'(k >> 1), MD_OFFSET, 13'h0002);
      req_signed = ~k[0];
      go();
      chk("extended load", {4'h1, e[k]}, wbq[0]);
    end
    req_op = OP_STORE;
    req_signed = 1;
    bad();
  endtask : t_ext

  task t_modes;
    base_value = 32'h40;
    for (int k = 0; k < 3; k++)
    begin
      rq(OP_LOAD, SZ_WORD, lsau_mode_type'(k), 13'h0008);
      req_imm_add = 0;
      go();
      chk("addr", k == 2 ? 32'h40 : 32'h38, mq[0][31:0]);
      chk("data", {4'h1, wat(k == 2 ? 32'h40 : 32'h38)}, wbq[0]);
      chk("base wb", k > 0 ? {4'h5, 32'h38} : 36'h0, bwb);
    end
    base_value = 32'h41;
    rq(OP_LOAD, SZ_WORD, MD_OFFSET, 13'h0FFF);
    go();
    chk("fault", 0, flt);
    rq(OP_LOAD, SZ_WORD, MD_PRE, 13'h0100);
    bad();
    rq(OP_LOAD, SZ_WORD, MD_OFFSET, 13'h0100);
    req_imm_add = 0;
    bad();
    rq(OP_LOAD, SZ_WORD, MD_POST, 13'h0004);
    base_register = 4'h1;
    bad();
  endtask : t_modes

  task t_dual;
    // slow memory so both halves wait on the far side
    lat = 4'h4;
    base_value = 32'h10;
    rq(OP_DUAL_LOAD, SZ_WORD, MD_OFFSET, 13'h0008);
    go();
    chk("addr1", 32'h18, mq[0][31:0]);
    chk("addr2", 32'h1C, mq[1][31:0]);
    chk("wb1", {4'h1, wat(32'h18)}, wbq[0]);
    chk("wb2", {4'h2, wat(32'h1C)}, wbq[1]);
    lat = 4'h1;
    req_imm = 13'h0006;
    bad();
    req_imm = 13'h0400;
    bad();
    req_imm = 13'h03FC;
    go();
    chk("fault", 0, flt);
    second_transfer_register = 4'h1;
    bad();
    rq(OP_DUAL_STORE, SZ_WORD, MD_PRE, 13'h0008);
    base_register = 4'h2;
    bad();
    // second word of a store must carry its own data, not the first word again
    store_data = 32'hA1B2_C3D4;
    store_data2 = 32'h5E6F_7081;
    rq(OP_DUAL_STORE, SZ_WORD, MD_OFFSET, 13'h0008);
    go();
    chk("st addr1", {1'b1, 4'hF, 32'h18}, mq[0]);
    chk("st addr2", {1'b1, 4'hF, 32'h1C}, mq[1]);
    chk("st data2", 32'h5E6F_7081, wd);
    chk("st no wb", 0, wbq.size());
  endtask : t_dual

  task t_pc;
    base_value = 32'h0;
    rq(OP_LOAD, SZ_WORD, MD_OFFSET, 13'h0004);
    transfer_register = REG_PC;
    go();
    chk("target", 32'h80F1_7F00, brt);
    chk("branches", 1, brn);
    req_imm = 13'h0008;
    go();
    chk("fault", 1, flt);
    chk("branches", 0, brn);
    req_imm = 13'h0004;
    req_conditional = 1;
    bad();
    req_group_last = 1;
    go();
    chk("branches", 1, brn);
    req_size = SZ_BYTE;
    bad();
  endtask : t_pc

  task t_reg;
    base_value = 32'h8;
    offset_value = 32'h4;
    rq(OP_LOAD, SZ_WORD, MD_REGISTER, 13'h0000);
    left_shift_amount = 2'h3;
    go();
    chk("addr", 32'h28, mq[0][31:0]);
    chk("base wb", 0, bcnt);
    offset_register = REG_SP;
    bad();
    offset_register = 4'h6;
    base_register = REG_PC;
    bad();
  endtask : t_reg

  task t_st;
    base_value = 32'h30;
    store_data = 32'h1234_56A5;
    rq(OP_STORE, SZ_BYTE, MD_OFFSET, 13'h0003);
    go();
    chk("byte store", {1'b1, 4'h8, 32'h33}, mq[0]);
    chk("byte lane", 8'hA5, wd[31:24]);
    req_size = SZ_HALF;
    req_imm = 13'h0002;
    go();
    chk("half store", {1'b1, 4'hC, 32'h32}, mq[0]);
    chk("half lane", 16'h56A5, wd[31:16]);
    transfer_register = REG_SP;
    bad();
    transfer_register = 4'h1;
    base_register = REG_PC;
    bad();
  endtask : t_st

  initial
  begin
    lat = 4'h1;
    {pc_value, base_value, offset_value, store_data, store_data2} = '0;
    rq(OP_ADR, SZ_WORD, MD_OFFSET, 13'h0000);
    repeat (20) @(posedge clk);
    #1 rstn = 1;
    t_adr();
    t_ext();
    t_modes();
    t_dual();
    t_pc();
    t_reg();
    t_st();
    final_report();
  end
endmodule : test_lsau_top
